// ==== gyro_cfg_regs.vh ====
// register offsets, field positions, reset values and timing constants
`ifndef GYRO_CFG_REGS_VH
`define GYRO_CFG_REGS_VH
`define OFS_Z_OFFSET_LOW     8'h18
`define OFS_SAMPLE_DIV       8'h19
`define OFS_FILTER_CFG       8'h1A
`define OFS_Z_OFFSET_HIGH    8'h17
`define OFS_STATUS           8'h40
`define OFS_RATE_INFO        8'h41
`define CFG_RESET            8'h00
`define CFG_WRITE_MASK       8'h7F
`define CFG_MODE_BIT         6
`define CFG_SYNC_HI          5
`define CFG_SYNC_LO          3
`define CFG_FILT_HI          2
`define CFG_FILT_LO          0
`define FILT_MIN_DIV         3'h1
`define FILT_MAX_DIV         3'h6
`define SYNC_OFF             3'h0
`define BYPASS_NONE          2'h0
`define BYPASS_SLOW          2'h2
`define CLOCK_HZ             100000000
`define BASE_RATE_HZ         1000
`define RATE_1K_HZ           16'h03E8
`define RATE_8K_HZ           16'h1F40
`define RATE_32K_HZ          16'h7D00
`endif

// ==== gyro_rate_filter_config.v ====
// gyro offset, sample-rate divider, filter select, frame sync and fifo feed
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "gyro_cfg_regs.vh"
// How it works
// - offset low register is bits 7..0
// - offset added to raw gyro before output
// - rate is 1 kHz over divider plus one
// - divided strobe updates outputs and fifo
// - divider used only bypass 00, filter 1..6
// - mode 1: full fifo drops new writes
// - mode 0: full fifo overwrites oldest data
// - sync latched once until sample strobe
// - filter field used only with bypass 00
// - filtering from field and bypass together
// - bypass bit0: 32 kHz, 8173 Hz, 4000 Hz
// - bypass 10: 32 kHz, 3281 Hz
// - field 0: 8 kHz, 250 Hz, 4000 Hz
// - field 1..6: 1 kHz, table bandwidths
// - field 7: 8 kHz, 3281 Hz, 4000 Hz
module gyro_rate_filter_config #(
  parameter DIV_BASE   = `CLOCK_HZ / `BASE_RATE_HZ,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  address,
  input  wire [7:0]  write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [7:0]  read_data,
  input  wire [1:0]  filter_bypass_bits,
  input  wire        frame_sync_input,
  input  wire [15:0] raw_gyro_z,
  input  wire        raw_gyro_z_valid,
  output reg  [15:0] gyro_z_out,
  output reg  [2:0]  sync_position,
  output reg         sync_bit,
  output wire        sample_strobe,
  output reg  [15:0] gyro_bandwidth_hz,
  output reg  [15:0] temp_bandwidth_hz,
  output reg  [15:0] internal_rate_hz,
  output wire        fifo_out_valid,
  input  wire        fifo_out_ready,
  output wire [15:0] fifo_out_data,
  output wire        fifo_full
);
  localparam DIV_W = 17;
  reg  [7:0]       offset_low_reg;
  reg  [7:0]       offset_high_reg;
  reg  [7:0]       divider_reg;
  reg  [7:0]       config_reg;
  reg  [DIV_W-1:0] tick_cnt_reg;
  reg  [7:0]       sample_cnt_reg;
  reg              sync_latch_reg;
  reg              sync_armed_reg;
  reg              sync_prev_reg;
  reg              dropped_reg;
  reg  [15:0]      held_gyro_reg;
  wire [2:0]       filter_cfg;
  wire [2:0]       sync_sel;
  wire             divider_on;
  wire             base_tick;
  wire             fifo_empty;
  wire             fifo_drop;
  wire [15:0]      corrected;

  assign filter_cfg = config_reg[`CFG_FILT_HI:`CFG_FILT_LO];
  assign sync_sel   = config_reg[`CFG_SYNC_HI:`CFG_SYNC_LO];

  // divider valid only in the 1 kHz filter settings
  assign divider_on = (filter_bypass_bits == `BYPASS_NONE) &&
                      (filter_cfg >= `FILT_MIN_DIV) &&
                      (filter_cfg <= `FILT_MAX_DIV);

  // offset assembled as 16-bit two's complement and added
  assign corrected = raw_gyro_z + {offset_high_reg, offset_low_reg};

  // register writes
  always @(posedge clock) begin
    if (rst) begin
      offset_low_reg  <= `CFG_RESET;
      offset_high_reg <= `CFG_RESET;
      divider_reg     <= `CFG_RESET;
      config_reg      <= `CFG_RESET;
    end else if (write_strobe) begin
      case (address)
        `OFS_Z_OFFSET_LOW:  offset_low_reg  <= write_data;
        `OFS_Z_OFFSET_HIGH: offset_high_reg <= write_data;
        `OFS_SAMPLE_DIV:    divider_reg     <= write_data;
        `OFS_FILTER_CFG:    config_reg      <= write_data & `CFG_WRITE_MASK;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      case (address)
        `OFS_Z_OFFSET_LOW:  read_data <= offset_low_reg;
        `OFS_Z_OFFSET_HIGH: read_data <= offset_high_reg;
        `OFS_SAMPLE_DIV:    read_data <= divider_reg;
        `OFS_FILTER_CFG:    read_data <= config_reg;
        `OFS_STATUS:        read_data <= {4'h0, dropped_reg, sync_latch_reg,
                                          fifo_full, fifo_empty};
        `OFS_RATE_INFO:     read_data <= {7'h00, divider_on};
        default:            read_data <= 8'h00;
      endcase
    end else begin
      read_data <= 8'h00;
    end
  end

  // 1 kHz base tick from the system clock
  assign base_tick = (tick_cnt_reg == DIV_BASE - 1);
  always @(posedge clock) begin
    if (rst)
      tick_cnt_reg <= {DIV_W{1'b0}};
    else if (base_tick)
      tick_cnt_reg <= {DIV_W{1'b0}};
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  // sample strobe every divider+1 base ticks when enabled
  assign sample_strobe = base_tick &&
                         (!divider_on || sample_cnt_reg >= divider_reg);
  always @(posedge clock) begin
    if (rst)
      sample_cnt_reg <= 8'h00;
    else if (sample_strobe)
      sample_cnt_reg <= 8'h00;
    else if (base_tick)
      sample_cnt_reg <= sample_cnt_reg + 1'b1;
  end

  // frame sync latch: one toggle held until sampled
  always @(posedge clock) begin
    if (rst) begin
      sync_prev_reg  <= 1'b0;
      sync_latch_reg <= 1'b0;
      sync_armed_reg <= 1'b1;
    end else begin
      sync_prev_reg <= frame_sync_input;
      // an edge meeting a strobe still toggles; the next strobe captures it
      if (sync_armed_reg && (frame_sync_input != sync_prev_reg)) begin
        sync_latch_reg <= ~sync_latch_reg;
        sync_armed_reg <= 1'b0;
      end else if (sample_strobe)
        sync_armed_reg <= 1'b1;
    end
  end

  // hold latest corrected sample, publish on sample strobe
  always @(posedge clock) begin
    if (rst) begin
      held_gyro_reg <= 16'h0000;
      gyro_z_out    <= 16'h0000;
      sync_position <= `SYNC_OFF;
      sync_bit      <= 1'b0;
    end else begin
      if (raw_gyro_z_valid)
        held_gyro_reg <= corrected;
      if (sample_strobe) begin
        sync_position <= sync_sel;
        sync_bit      <= (sync_sel != `SYNC_OFF) && sync_latch_reg;
        // gyro z low byte lsb carries sync when selected
        if (sync_sel == 3'h4)
          gyro_z_out <= {held_gyro_reg[15:1], sync_latch_reg};
        else
          gyro_z_out <= held_gyro_reg;
      end
    end
  end

  // filter bandwidth and internal rate selection
  always @(posedge clock) begin
    if (rst) begin
      gyro_bandwidth_hz <= 16'd250;
      temp_bandwidth_hz <= 16'd4000;
      internal_rate_hz  <= `RATE_8K_HZ;
    end else if (filter_bypass_bits[0]) begin
      gyro_bandwidth_hz <= 16'd8173;
      temp_bandwidth_hz <= 16'd4000;
      internal_rate_hz  <= `RATE_32K_HZ;
    end else if (filter_bypass_bits == `BYPASS_SLOW) begin
      gyro_bandwidth_hz <= 16'd3281;
      temp_bandwidth_hz <= 16'd4000;
      internal_rate_hz  <= `RATE_32K_HZ;
    end else begin
      case (filter_cfg)
        3'h0: begin
          gyro_bandwidth_hz <= 16'd250;
          temp_bandwidth_hz <= 16'd4000;
          internal_rate_hz  <= `RATE_8K_HZ;
        end
        3'h1: begin
          gyro_bandwidth_hz <= 16'd176;
          temp_bandwidth_hz <= 16'd188;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        3'h2: begin
          gyro_bandwidth_hz <= 16'd92;
          temp_bandwidth_hz <= 16'd98;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        3'h3: begin
          gyro_bandwidth_hz <= 16'd41;
          temp_bandwidth_hz <= 16'd42;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        3'h4: begin
          gyro_bandwidth_hz <= 16'd20;
          temp_bandwidth_hz <= 16'd20;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        3'h5: begin
          gyro_bandwidth_hz <= 16'd10;
          temp_bandwidth_hz <= 16'd10;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        3'h6: begin
          gyro_bandwidth_hz <= 16'd5;
          temp_bandwidth_hz <= 16'd5;
          internal_rate_hz  <= `RATE_1K_HZ;
        end
        default: begin
          gyro_bandwidth_hz <= 16'd3281;
          temp_bandwidth_hz <= 16'd4000;
          internal_rate_hz  <= `RATE_8K_HZ;
        end
      endcase
    end
  end

  // sticky drop flag, cleared by a status read; a new drop wins
  always @(posedge clock) begin
    if (rst)
      dropped_reg <= 1'b0;
    else if (fifo_drop)
      dropped_reg <= 1'b1;
    else if (read_strobe && address == `OFS_STATUS)
      dropped_reg <= 1'b0;
  end

  // fifo written on each sample strobe, except when full in mode 1 (drop)
  sample_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) fifo (
    .clock     (clock),
    .rst       (rst),
    .overwrite (!config_reg[`CFG_MODE_BIT]),
    .in_valid  (sample_strobe),
    .in_ready  (),
    .in_data   (gyro_z_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .dropped   (fifo_drop)
  );
endmodule

// ==== gyro_rate_filter_config_assertions.sv ====
// port checker for the gyro rate and filter block
`timescale 1ns/1ns
module gyro_cfg_checker #(
  parameter DIV_BASE = 10
) (
  input wire        clock,
  input wire        rst,
  input wire [1:0]  filter_bypass_bits,
  input wire        sample_strobe,
  input wire [15:0] gyro_z_out,
  input wire [2:0]  sync_position,
  input wire        sync_bit,
  input wire [15:0] gyro_bandwidth_hz,
  input wire [15:0] temp_bandwidth_hz,
  input wire [15:0] internal_rate_hz,
  input wire        fifo_out_valid,
  input wire        fifo_full
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_fast_bypass: assert property (filter_bypass_bits[0] [*3] |->
    gyro_bandwidth_hz == 16'h1FED && temp_bandwidth_hz == 16'h0FA0
    && internal_rate_hz == 16'h7D00) else $error("fast bypass settings wrong");
  a_slow_bypass: assert property (filter_bypass_bits == 2'h2 [*3] |->
    gyro_bandwidth_hz == 16'h0CD1 && internal_rate_hz == 16'h7D00)
    else $error("slow bypass settings wrong");
  a_filter_gate: assert property (filter_bypass_bits != 2'h0 [*3] |->
    internal_rate_hz != 16'h03E8) else $error("filter used while bypassed");
  a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("sample strobes too close");
  a_out_hold: assert property (!sample_strobe |=> $stable(gyro_z_out))
    else $error("output changed without strobe");
  a_sync_hold: assert property (!sample_strobe |=>
    $stable({sync_position, sync_bit})) else $error("sync changed without strobe");
  a_sync_off: assert property (sync_position == 3'h0 |-> !sync_bit)
    else $error("sync bit set while disabled");
  a_full_valid: assert property (fifo_full |-> fifo_out_valid)
    else $error("full fifo shows no data");
  c_strobe: cover property (sample_strobe);
  c_full: cover property (fifo_full);
  c_sync: cover property (sync_bit);
endmodule
bind gyro_rate_filter_config gyro_cfg_checker #(.DIV_BASE(DIV_BASE)) u_gyro_cfg_checker (
  .clock(clock), .rst(rst), .filter_bypass_bits(filter_bypass_bits),
  .sample_strobe(sample_strobe), .gyro_z_out(gyro_z_out), .sync_position(sync_position),
  .sync_bit(sync_bit), .gyro_bandwidth_hz(gyro_bandwidth_hz),
  .temp_bandwidth_hz(temp_bandwidth_hz), .internal_rate_hz(internal_rate_hz),
  .fifo_out_valid(fifo_out_valid), .fifo_full(fifo_full));

// ==== sample_fifo.v ====
// sample fifo with valid/ready on both sides and overwrite option
`timescale 1ns/1ns
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             overwrite,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             full,
  output wire             empty,
  output wire             dropped
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      count_reg;
  wire            pop;
  wire            push;
  wire            evict;

  assign full      = (count_reg == DEPTH);
  assign empty     = (count_reg == {(AW+1){1'b0}});
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg];
  assign pop       = out_valid && out_ready;
  // full-and-overwrite accepts, dropping the oldest entry
  assign in_ready  = !full || pop || overwrite;
  assign push      = in_valid && in_ready;
  assign evict     = push && full && !pop;
  assign dropped   = in_valid && !in_ready;

  // pointers and occupancy
  always @(posedge clock) begin
    if (rst) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg      <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop || evict)
        rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
      if (push && !pop && !evict)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ==== sensor_feed_model.sv ====
// raw sample source and fifo reader facing the sample path
`timescale 1ns/1ns
module sensor_feed_model (
  input  wire        clock,
  input  wire        rst,
  input  wire        sample_strobe,
  input  wire        stall,
  input  wire        slow,
  output reg  [15:0] raw_gyro_z,
  output reg         raw_gyro_z_valid,
  output reg         fifo_out_ready
);
  reg [15:0] seq_reg;
  // one sample just after each strobe; idle data inverted so it never looks held
  always @(posedge clock) begin
    if (rst) begin
      seq_reg <= 16'h1234;
      raw_gyro_z <= 16'h0000;
      raw_gyro_z_valid <= 1'b0;
      fifo_out_ready <= 1'b0;
    end else begin
      raw_gyro_z_valid <= sample_strobe;
      raw_gyro_z <= sample_strobe ? seq_reg : ~raw_gyro_z;
      if (sample_strobe)
        seq_reg <= seq_reg * 16'h0005 + 16'h03C1;
      fifo_out_ready <= !stall && (!slow || !fifo_out_ready);
    end
  end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the gyro rate and filter block
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  localparam DB = 10;
  reg        clock = 0, rst = 1, write_strobe = 0, read_strobe = 0;
  reg        frame_sync_input = 0, stall = 0, slow = 0;
  reg  [7:0] address = 0, write_data = 0;
  reg  [1:0] filter_bypass_bits = 0;
  wire [7:0] read_data;
  wire [15:0] raw_gyro_z, gyro_z_out, gyro_bandwidth_hz, temp_bandwidth_hz;
  wire [15:0] internal_rate_hz, fifo_out_data;
  wire [2:0] sync_position;
  wire       raw_gyro_z_valid, sync_bit, sample_strobe;
  wire       fifo_out_valid, fifo_out_ready, fifo_full;
  int        fails = 0, checked = 0, s = 51, n, v;
  bit        mode;
  logic [15:0] off = 0, mout, pend, q[$];
  logic [7:0] ra[4] = '{8'h17, 8'h18, 8'h19, 8'h1A};
  logic [1:0] cb[5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
  logic [7:0] cf[5] = '{8'h01, 8'h06, 8'h07, 8'h03, 8'h00};
  logic [7:0] cd[5] = '{8'h02, 8'hFF, 8'h02, 8'h02, 8'h05};
  always #5 clock = ~clock;
  gyro_rate_filter_config #(.DIV_BASE(DB)) u_gyro_rate_filter_config (
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .filter_bypass_bits(filter_bypass_bits), .frame_sync_input(frame_sync_input),
    .raw_gyro_z(raw_gyro_z), .raw_gyro_z_valid(raw_gyro_z_valid), .gyro_z_out(gyro_z_out),
    .sync_position(sync_position), .sync_bit(sync_bit), .sample_strobe(sample_strobe),
    .gyro_bandwidth_hz(gyro_bandwidth_hz), .temp_bandwidth_hz(temp_bandwidth_hz),
    .internal_rate_hz(internal_rate_hz), .fifo_out_valid(fifo_out_valid),
    .fifo_out_ready(fifo_out_ready), .fifo_out_data(fifo_out_data), .fifo_full(fifo_full));
  sensor_feed_model u_sensor_feed_model (
    .clock(clock), .rst(rst), .sample_strobe(sample_strobe), .stall(stall), .slow(slow),
    .raw_gyro_z(raw_gyro_z), .raw_gyro_z_valid(raw_gyro_z_valid),
    .fifo_out_ready(fifo_out_ready));
  // reference of held sample, pending sample and fifo contents
  always @(posedge clock) begin
    if (rst) begin
      mout = 0;
      pend = 0;
      q.delete();
    end else begin
      if (fifo_out_valid && fifo_out_ready)
        `CHK(fifo_out_data, q.pop_front())
      if (sample_strobe) begin
        if (q.size() == 32 && !mode)
          void'(q.pop_front());
        if (q.size() < 32)
          q.push_back(mout);
        mout = pend;
      end
      if (raw_gyro_z_valid)
        pend = raw_gyro_z + off;
    end
  end
  always @(negedge clock)
    if (!rst) `CHK(gyro_z_out, mout)
  function int xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic [47:0] tbl(input int b, input int f);
    logic [15:0] g[6] = '{16'h00B0, 16'h005C, 16'h0029, 16'h0014, 16'h000A, 16'h0005};
    logic [15:0] t[6] = '{16'h00BC, 16'h0062, 16'h002A, 16'h0014, 16'h000A, 16'h0005};
    if (b[0]) return {16'h1FED, 16'h0FA0, 16'h7D00};
    if (b == 2) return {16'h0CD1, 16'h0FA0, 16'h7D00};
    if (f == 0) return {16'h00FA, 16'h0FA0, 16'h1F40};
    if (f == 7) return {16'h0CD1, 16'h0FA0, 16'h1F40};
    return {g[f-1], t[f-1], 16'h03E8};
  endfunction
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1;
    @(posedge clock);
    write_strobe <= 0;
    if (a == 8'h17) off[15:8] = d;
    if (a == 8'h18) off[7:0] = d;
    if (a == 8'h1A) mode = d[6];
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    @(posedge clock);
    address <= a;
    read_strobe <= 1;
    @(posedge clock);
    read_strobe <= 0;
    @(negedge clock);
    `CHK(read_data, e)
  endtask
  task automatic ws(output int c);
    c = 0;
    do begin @(negedge clock); c++; end while (!sample_strobe && c < 4000);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog for a hung handshake or strobe
  initial begin
    #600000;
    fails++;
    end_of_test();
  end
  // reset, registers, filter table, divider, sync latch, fifo modes
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h55, 8'h00);
    foreach (ra[i]) begin
      v = xs();
      if (i == 3) v = v & 8'hC7 | 8'h80;
      wr(ra[i], v);
      rd(ra[i], i == 3 ? v & 8'h7F : v);
    end
    for (int b = 0; b < 4; b++)
      for (int f = 0; f < 8; f++) begin
        @(posedge clock);
        filter_bypass_bits <= b;
        wr(8'h1A, f);
        repeat (4) @(negedge clock);
        `CHK({gyro_bandwidth_hz, temp_bandwidth_hz, internal_rate_hz}, tbl(b, f))
      end
    foreach (cb[i]) begin
      @(posedge clock);
      filter_bypass_bits <= cb[i];
      wr(8'h19, cd[i]);
      wr(8'h1A, cf[i]);
      repeat (3) ws(n);
      v = (cb[i] == 0 && cf[i] > 0 && cf[i] < 7) ? DB * (cd[i] + 1) : DB;
      `CHK(n, v)
      rd(8'h41, (cb[i] == 0 && cf[i] > 0 && cf[i] < 7) ? 8'h01 : 8'h00);
    end
    wr(8'h19, 8'h00);
    wr(8'h1A, 8'h09);
    ws(n);
    @(posedge clock) frame_sync_input <= 1;
    @(posedge clock) frame_sync_input <= 0;
    ws(n);
    @(negedge clock);
    `CHK({sync_position, sync_bit}, 4'h3)
    for (int m = 0; m < 2; m++) begin
      wr(8'h1A, m ? 8'h00 : 8'h40);
      stall <= 1;
      repeat (40) ws(n);
      `CHK(fifo_full, 1'b1)
      rd(8'h40, 8'h0E);
      ws(n);
      @(posedge clock);
      slow <= m;
      stall <= 0;
      repeat (300) @(posedge clock);
    end
    end_of_test();
  end
endmodule
